/* common/setpoint_relay_pkg.sv */
// Constants, types and register map of the setpoint relay controller
// Function
// - All four setpoints are compared on every reading, fitted relay or not, so each still feeds indication.
// - A setpoint at the top of the reading range in high mode, or at the bottom in low mode, never trips.
// - The setpoint one relay energizes only after the alarm condition has held unbroken for the make delay.
// - The setpoint one relay de-energizes only after the non-alarm condition has held unbroken for the break delay.
// - Setpoints two to four follow their comparison at once, with no make or break wait.
// - Every setpoint has its own hysteresis on/off setting applied to its own comparison, except setpoint one while the pump band is active.
// - With pump mode on and setpoint two above setpoint one, the setpoint one relay works on the band between them.
// - In pump mode with low direction, the relay turns on below setpoint one and stays on until setpoint two.
// - In pump mode with high direction, the relay turns on above setpoint two and stays on until setpoint one.
// - Programming walks setpoint one, make, break, hysteresis, pump, then two to four with hysteresis, then directions.
// - Each setpoint has a direction bit: high trips above the setpoint, low trips below it.
package setpoint_relay_pkg;

  localparam int READING_W = 16;
  localparam int DELAY_W = 14;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_SP = 4;

  // Reading range ends: +9999 and -1999 counts
  localparam logic [READING_W-1:0] READING_MAX = 16'h270F;
  localparam logic [READING_W-1:0] READING_MIN = 16'hF831;
  localparam logic DIR_HIGH = 1'b1;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_SP1 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_SP2 = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_SP3 = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_SP4 = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_MAKE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_BREAK = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_PROG_DATA = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_PROG_CTRL = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_HYSTERESIS_ENABLE_BAND = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h2C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_LAST_READING = 8'h34;

  // Field positions
  localparam int CFG_HYSTERESIS_ENABLE_LSB = 0;
  localparam int CFG_PUMP_BIT = 4;
  localparam int CFG_DIR_LSB = 8;
  localparam int STAT_RELAY_LSB = 0;
  localparam int STAT_ALARM_LSB = 4;
  localparam int STAT_EVAL_BIT = 8;
  localparam int STAT_BAND_BIT = 9;
  localparam int CTRL_RESTART_BIT = 0;

  // Values after reset
  localparam logic [READING_W-1:0] SP_RESET = 16'h270F;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 14'h0000;
  localparam logic [NUM_SP-1:0] HYSTERESIS_ENABLE_EN_RESET = 4'h0;
  localparam logic [NUM_SP-1:0] DIR_RESET = 4'hF;
  localparam logic [READING_W-1:0] HYSTERESIS_ENABLE_BAND_RESET = 16'h0002;
  localparam logic [NUM_SP-1:0] IRQ_MASK_RESET = 4'h0;

  typedef enum logic [11:0] {
    ST_SP1 = 12'h001,
    ST_MAKE = 12'h002,
    ST_BREAK = 12'h004,
    ST_HYST1 = 12'h008,
    ST_PUMP = 12'h010,
    ST_SP2 = 12'h020,
    ST_HYST2 = 12'h040,
    ST_SP3 = 12'h080,
    ST_HYST3 = 12'h100,
    ST_SP4 = 12'h200,
    ST_HYST4 = 12'h400,
    ST_DIR = 12'h800
  } prog_step_t;

  typedef struct packed {
    logic [NUM_SP-1:0][READING_W-1:0] sp;
    logic [DELAY_W-1:0] make_delay;
    logic [DELAY_W-1:0] break_delay;
    logic [NUM_SP-1:0] hysteresis_enable;
    logic pump_band_enable;
    logic [NUM_SP-1:0] relay_direction_set;
  } relay_settings_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [READING_W-1:0] value;
    logic valid;
  } reading_t;

endpackage

/* dv/relay_panel_model.sv */
// Relay coils and front-panel annunciators facing the controller outputs
`timescale 1ns/1ps
module relay_panel_model (
  input wire logic mclk,
  input wire logic [3:0] relay_drive,
  input wire logic [3:0] indicator,
  output logic [3:0] contact,
  output logic [3:0] lamp
);
  // Armature lags its coil drive by one clock, so checks must allow for it
  always_ff @(posedge mclk) begin
    contact <= relay_drive;
    lamp <= indicator;
  end
endmodule

/* dv/setpoint_relay_controller_tb.sv */
// Self-checking bench for the setpoint relay controller
`timescale 1ns/1ps
module setpoint_relay_controller_tb;
  import setpoint_relay_pkg::*;
  // Two relays left out so unfitted setpoints still show on the lamps
  localparam logic [3:0] FIT = 4'h5;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  reg_req_t req = '0;
  reading_t rdg_in = '0;
  logic sec_tick = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [3:0] relay_drive, indicator, contact, lamp;
  logic irq;
  int err_count = 0;
  int n_tests = 0;
  logic [15:0] sp [4];
  logic [3:0] hen, dir, st;
  logic [15:0] band;
  logic [31:0] rv;

  always #20 mclk = ~mclk;

  setpoint_relay_controller #(.RELAYS_FITTED(FIT)) dut (.mclk(mclk), .rst(rst), .reg_req(req),
    .reg_rdata(reg_rdata), .reading(rdg_in), .sec_tick(sec_tick), .relay_drive(relay_drive),
    .indicator(indicator), .irq(irq));
  relay_panel_model panel (.mclk(mclk), .relay_drive(relay_drive), .indicator(indicator),
    .contact(contact), .lamp(lamp));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req <= '0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req <= '0;
    #1 d = reg_rdata;
    @(posedge mclk);
  endtask

  function automatic logic exp_alarm(input logic hi, cur, h, input logic [15:0] r, s, b);
    if (hi) return (s != READING_MAX) && ($signed(r) > $signed(cur && h ? s - b : s));
    return (s != READING_MIN) && ($signed(r) < $signed(cur && h ? s + b : s));
  endfunction

  // Kept inside the reading range even after a small offset around a setpoint
  function automatic logic [15:0] rnd();
    return 16'($urandom_range(11990)) - 16'h07CB;
  endfunction

  task automatic feed(input int v, input logic all4);
    rdg_in <= '{value: v[15:0], valid: 1'b1};
    @(posedge mclk);
    rdg_in.valid <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (i > 0 || all4) st[i] = exp_alarm(dir[i], st[i], hen[i], v[15:0], sp[i], band);
    end
    repeat (3) @(posedge mclk);
    #1;
    chk(indicator, st);
    chk(contact, st & FIT);
    chk(lamp, st);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      sec_tick <= 1'b1;
      @(posedge mclk);
      sec_tick <= 1'b0;
      @(posedge mclk);
    end
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic prog(input logic [15:0] s1, mk, bk, input logic [3:0] h, input logic pm,
                      input logic [15:0] s2, s3, s4, input logic [3:0] d);
    logic [15:0] seq [12];
    seq = '{s1, mk, bk, 16'(h[0]), 16'(pm), s2, 16'(h[1]), s3, 16'(h[2]), s4, 16'(h[3]), 16'(d)};
    wr(OFF_PROG_CTRL, 32'h0000_0001);
    foreach (seq[i]) wr(OFF_PROG_DATA, {16'h0000, seq[i]});
    sp = '{s1, s2, s3, s4};
    hen = h;
    dir = d;
    rd(OFF_PROG_DATA, rv);
    chk(rv, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      rd(OFF_SP1 + 8'(4 * i), rv);
      chk(rv, {{16{sp[i][15]}}, sp[i]});
    end
    rd(OFF_MAKE, rv);
    chk(rv, {18'h0_0000, mk[13:0]});
    rd(OFF_BREAK, rv);
    chk(rv, {18'h0_0000, bk[13:0]});
    rd(OFF_CONFIG, rv);
    chk(rv, {20'h0_0000, d, 3'b000, pm, h});
  endtask

  // Cuts a hang short
  initial begin
    repeat (40000) @(posedge mclk);
    err_count++;
    close_out();
  end

  initial begin
    int cv[6] = '{-1999, 300, 301, 296, 295, 150};
    int pl[9] = '{150, 90, 150, 200, 150, 150, 210, 150, 100};
    logic pe[9] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    int r;
    r = $urandom(32'h0000_a812);
    st = 4'h0;
    band = HYSTERESIS_ENABLE_BAND_RESET;
    sp = '{SP_RESET, SP_RESET, SP_RESET, SP_RESET};
    hen = HYSTERESIS_ENABLE_EN_RESET;
    dir = DIR_RESET;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk(relay_drive, 32'h0000_0000);
    rd(OFF_CONFIG, rv);
    chk(rv, 32'h0000_0F00);
    rd(8'h40, rv);
    chk(rv, 32'h0000_0000);
    wr(OFF_SP1, 32'h0000_0005);
    rd(OFF_SP1, rv);
    chk(rv, 32'h0000_270F);
    feed(9999, 1'b1);
    wr(OFF_HYSTERESIS_ENABLE_BAND, 32'h0000_0005);
    band = 16'h0005;
    rd(OFF_HYSTERESIS_ENABLE_BAND, rv);
    chk(rv, 32'h0000_0005);
    // Random settings, readings often landing near a setpoint
    repeat (4) begin
      prog(rnd(), 16'h0000, 16'h0000, 4'($urandom), 1'b0, rnd(), rnd(), rnd(), 4'($urandom));
      repeat (30) begin
        if ($urandom_range(1)) feed(rnd(), 1'b1);
        else feed(sp[$urandom_range(3)] + 16'($urandom_range(6)) - 16'h0003, 1'b1);
      end
    end
    // Edge values, bottom-range low setpoint and hysteresis hold on setpoint three
    prog(16'd100, 16'h0000, 16'h0000, 4'h4, 1'b0, 16'd200, 16'd300, READING_MIN, 4'h7);
    foreach (cv[i]) feed(cv[i], 1'b1);
    wr(OFF_IRQ_STATUS, 32'h0000_000F);
    wr(OFF_IRQ_MASK, 32'h0000_0004);
    feed(400, 1'b1);
    chk(irq, 1'b1);
    rd(OFF_LAST_READING, rv);
    chk(rv, 32'h0000_0190);
    rd(OFF_IRQ_STATUS, rv);
    chk(rv[2], 1'b1);
    wr(OFF_IRQ_STATUS, 32'h0000_0004);
    #1;
    chk(irq, 1'b0);
    wr(OFF_IRQ_MASK, 32'h0000_0000);
    feed(100, 1'b1);
    chk(irq, 1'b0);
    // Make delay of three ticks with a restart, then break delay of two
    prog(16'd100, 16'd3, 16'd2, 4'h0, 1'b0, 16'd200, 16'd300, READING_MIN, 4'h7);
    feed(150, 1'b0);
    tick(2);
    chk(contact[0], 1'b0);
    feed(50, 1'b0);
    feed(150, 1'b0);
    tick(2);
    chk(contact[0], 1'b0);
    tick(1);
    chk(contact[0], 1'b1);
    st[0] = 1'b1;
    feed(50, 1'b0);
    tick(1);
    chk(contact[0], 1'b1);
    tick(1);
    chk(contact[0], 1'b0);
    st[0] = 1'b0;
    // Pump band: filling with low direction, then emptying with high
    prog(16'd100, 16'h0000, 16'h0000, 4'h0, 1'b1, 16'd200, 16'd300, READING_MIN, 4'h6);
    foreach (pl[i]) begin
      if (i == 5) prog(16'd100, 16'h0000, 16'h0000, 4'h0, 1'b1, 16'd200, 16'd300, READING_MIN, 4'h7);
      st[0] = pe[i];
      feed(pl[i], 1'b0);
    end
    rd(OFF_STATUS, rv);
    chk(rv[9], 1'b1);
    chk(rv[8], 1'b1);
    chk(rv[3:0], st);
    close_out();
  end
endmodule

/* rtl/setpoint_delay_timer.sv */
// Make and break delay timer for the setpoint one relay
`timescale 1ns/1ps
module setpoint_delay_timer #(
  parameter int DELAY_W = setpoint_relay_pkg::DELAY_W
) (
  input logic mclk,
  input logic rst,
  input logic sec_tick,
  input logic alarm,
  input logic [DELAY_W-1:0] make_delay,
  input logic [DELAY_W-1:0] break_delay,
  output logic relay
);
  import setpoint_relay_pkg::*;

  logic relay_reg;
  logic [DELAY_W-1:0] count_reg;
  wire pending = alarm != relay_reg;
  wire [DELAY_W-1:0] limit = alarm ? make_delay : break_delay;
  wire expired = count_reg >= limit;

  // Count restarts whenever the condition agrees with the relay again
  // Limitation: first tick may land early in the first second
  always_ff @(posedge mclk) begin
    if (rst) begin
      relay_reg <= 1'b0;
      count_reg <= '0;
    end else if (!pending) begin
      count_reg <= '0;
    end else if (expired) begin
      relay_reg <= alarm;
      count_reg <= '0;
    end else if (sec_tick) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  assign relay = relay_reg;

  a_make_wait_done: assert property (@(posedge mclk) disable iff (rst)
    $rose(relay_reg) |-> $past(count_reg) >= $past(make_delay) && $past(alarm))
    else $error("relay made before make delay elapsed");

  a_break_wait_done: assert property (@(posedge mclk) disable iff (rst)
    $fell(relay_reg) |-> $past(count_reg) >= $past(break_delay) && !$past(alarm))
    else $error("relay broke before break delay elapsed");

endmodule

/* rtl/setpoint_relay_controller.sv */
// Four-setpoint comparator with relay, indicator and register port
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module setpoint_relay_controller #(
  parameter logic [3:0] RELAYS_FITTED = 4'hF
) (
  input logic mclk,
  input logic rst,
  input setpoint_relay_pkg::reg_req_t reg_req,
  output logic [setpoint_relay_pkg::DATA_W-1:0] reg_rdata,
  input setpoint_relay_pkg::reading_t reading,
  input logic sec_tick,
  output logic [setpoint_relay_pkg::NUM_SP-1:0] relay_drive,
  output logic [setpoint_relay_pkg::NUM_SP-1:0] indicator,
  output logic irq
);
  import setpoint_relay_pkg::*;

  // Alarm condition for one setpoint, with optional hysteresis band
  function automatic logic eval_alarm(
    input logic dir_high,
    input logic cur,
    input logic hold_en,
    input logic [READING_W-1:0] rd,
    input logic [READING_W-1:0] sp,
    input logic [READING_W-1:0] band
  );
    logic signed [READING_W:0] r;
    logic signed [READING_W:0] s;
    logic signed [READING_W:0] b;
    logic never;
    logic trip;
    logic hold;
    r = $signed({rd[READING_W-1], rd});
    s = $signed({sp[READING_W-1], sp});
    b = $signed({1'b0, band});
    if (dir_high == DIR_HIGH) begin
      never = sp == READING_MAX;
      trip = r > s;
      hold = cur && hold_en && (r > s - b);
    end else begin
      never = sp == READING_MIN;
      trip = r < s;
      hold = cur && hold_en && (r < s + b);
    end
    return !never && (trip || hold);
  endfunction

  // Pump band for setpoint one: lower limit lo, upper limit hi
  function automatic logic eval_pump(
    input logic dir_high,
    input logic cur,
    input logic [READING_W-1:0] rd,
    input logic [READING_W-1:0] lo,
    input logic [READING_W-1:0] hi
  );
    logic signed [READING_W-1:0] r;
    logic signed [READING_W-1:0] l;
    logic signed [READING_W-1:0] h;
    r = $signed(rd);
    l = $signed(lo);
    h = $signed(hi);
    if (dir_high == DIR_HIGH) begin
      return (r > h) || (cur && r > l);
    end
    return (r < l) || (cur && r < h);
  endfunction

  // Programming order
  function automatic prog_step_t step_after(input prog_step_t s);
    prog_step_t n;
    n = ST_SP1;
    case (s)
      ST_SP1: n = ST_MAKE;
      ST_MAKE: n = ST_BREAK;
      ST_BREAK: n = ST_HYST1;
      ST_HYST1: n = ST_PUMP;
      ST_PUMP: n = ST_SP2;
      ST_SP2: n = ST_HYST2;
      ST_HYST2: n = ST_SP3;
      ST_SP3: n = ST_HYST3;
      ST_HYST3: n = ST_SP4;
      ST_SP4: n = ST_HYST4;
      ST_HYST4: n = ST_DIR;
      ST_DIR: n = ST_SP1;
      default: n = ST_SP1;
    endcase
    return n;
  endfunction

  relay_settings_t settings_reg;
  relay_settings_t settings_next;
  prog_step_t step_reg;
  prog_step_t step_next;
  logic [READING_W-1:0] hysteresis_enable_band_reg;
  logic [READING_W-1:0] last_reading_reg;
  logic [NUM_SP-1:0] alarm_reg;
  logic [NUM_SP-1:0] alarm_next;
  logic [NUM_SP-1:0] prev_state_reg;
  logic [NUM_SP-1:0] irq_status_reg;
  logic [NUM_SP-1:0] irq_status_next;
  logic [NUM_SP-1:0] irq_mask_reg;
  logic evaluated_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic relay_one;

  // Register decode
  wire hit_prog_data = reg_req.addr == OFF_PROG_DATA;
  wire prog_write = reg_req.wr && hit_prog_data;
  wire prog_restart = reg_req.wr && reg_req.addr == OFF_PROG_CTRL && reg_req.wdata[CTRL_RESTART_BIT];
  wire band_write = reg_req.wr && reg_req.addr == OFF_HYSTERESIS_ENABLE_BAND;
  wire mask_write = reg_req.wr && reg_req.addr == OFF_IRQ_MASK;
  wire [NUM_SP-1:0] irq_clear = (reg_req.wr && reg_req.addr == OFF_IRQ_STATUS) ?
    reg_req.wdata[NUM_SP-1:0] : '0;

  // Comparison of all four setpoints
  wire [READING_W-1:0] sp1 = settings_reg.sp[0];
  wire [READING_W-1:0] sp2 = settings_reg.sp[1];
  wire band_active = settings_reg.pump_band_enable && ($signed(sp2) > $signed(sp1));

  assign alarm_next[0] = band_active ?
    eval_pump(settings_reg.relay_direction_set[0], alarm_reg[0], reading.value, sp1, sp2) :
    eval_alarm(settings_reg.relay_direction_set[0], alarm_reg[0], settings_reg.hysteresis_enable[0],
      reading.value, sp1, hysteresis_enable_band_reg);

  // Evaluated regardless of RELAYS_FITTED
  genvar gi;
  generate
    for (gi = 1; gi < NUM_SP; gi++) begin : g_cmp
      assign alarm_next[gi] = eval_alarm(settings_reg.relay_direction_set[gi], alarm_reg[gi],
        settings_reg.hysteresis_enable[gi], reading.value, settings_reg.sp[gi], hysteresis_enable_band_reg);
    end
  endgenerate

  setpoint_delay_timer #(
    .DELAY_W(DELAY_W)
  ) u_delay (
    .mclk(mclk),
    .rst(rst),
    .sec_tick(sec_tick),
    .alarm(alarm_reg[0]),
    .make_delay(settings_reg.make_delay),
    .break_delay(settings_reg.break_delay),
    .relay(relay_one)
  );

  // Setpoints two to four bypass any timer
  wire [NUM_SP-1:0] relay_state = {alarm_reg[3:1], relay_one};
  wire [NUM_SP-1:0] state_events = relay_state ^ prev_state_reg;

  // Programming sequencer writes one field per step
  always_comb begin
    settings_next = settings_reg;
    if (prog_write) begin
      case (step_reg)
        ST_SP1: settings_next.sp[0] = reg_req.wdata[READING_W-1:0];
        ST_MAKE: settings_next.make_delay = reg_req.wdata[DELAY_W-1:0];
        ST_BREAK: settings_next.break_delay = reg_req.wdata[DELAY_W-1:0];
        ST_HYST1: settings_next.hysteresis_enable[0] = reg_req.wdata[0];
        ST_PUMP: settings_next.pump_band_enable = reg_req.wdata[0];
        ST_SP2: settings_next.sp[1] = reg_req.wdata[READING_W-1:0];
        ST_HYST2: settings_next.hysteresis_enable[1] = reg_req.wdata[0];
        ST_SP3: settings_next.sp[2] = reg_req.wdata[READING_W-1:0];
        ST_HYST3: settings_next.hysteresis_enable[2] = reg_req.wdata[0];
        ST_SP4: settings_next.sp[3] = reg_req.wdata[READING_W-1:0];
        ST_HYST4: settings_next.hysteresis_enable[3] = reg_req.wdata[0];
        ST_DIR: settings_next.relay_direction_set = reg_req.wdata[NUM_SP-1:0];
        default: settings_next = settings_reg;
      endcase
    end
  end

  assign step_next = prog_restart ? ST_SP1 : (prog_write ? step_after(step_reg) : step_reg);

  // Set wins over a clear in the same cycle
  assign irq_status_next = (irq_status_reg & ~irq_clear) | state_events;

  always_ff @(posedge mclk) begin
    if (rst) begin
      settings_reg <= '{sp: {NUM_SP{SP_RESET}}, make_delay: DELAY_RESET, break_delay: DELAY_RESET,
        hysteresis_enable: HYSTERESIS_ENABLE_EN_RESET, pump_band_enable: 1'b0, relay_direction_set: DIR_RESET};
      step_reg <= ST_SP1;
    end else begin
      settings_reg <= settings_next;
      step_reg <= step_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      hysteresis_enable_band_reg <= HYSTERESIS_ENABLE_BAND_RESET;
      irq_mask_reg <= IRQ_MASK_RESET;
    end else begin
      if (band_write) hysteresis_enable_band_reg <= reg_req.wdata[READING_W-1:0];
      if (mask_write) irq_mask_reg <= reg_req.wdata[NUM_SP-1:0];
    end
  end

  // Alarms move only on a new reading; reset value keeps relays off
  always_ff @(posedge mclk) begin
    if (rst) begin
      alarm_reg <= '0;
      evaluated_reg <= 1'b0;
      last_reading_reg <= '0;
    end else if (reading.valid) begin
      alarm_reg <= alarm_next;
      evaluated_reg <= 1'b1;
      last_reading_reg <= reading.value;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      prev_state_reg <= '0;
      irq_status_reg <= '0;
    end else begin
      prev_state_reg <= relay_state;
      irq_status_reg <= irq_status_next;
    end
  end

  // Read mux
  wire [DATA_W-1:0] cfg_word = {{(DATA_W-CFG_DIR_LSB-NUM_SP){1'b0}}, settings_reg.relay_direction_set,
    3'b000, settings_reg.pump_band_enable, settings_reg.hysteresis_enable};
  wire [DATA_W-1:0] stat_word = {{(DATA_W-STAT_BAND_BIT-1){1'b0}}, band_active, evaluated_reg,
    alarm_reg, relay_state};
  wire [DATA_W-1:0] read_word =
    (reg_req.addr == OFF_SP1) ? {{(DATA_W-READING_W){sp1[READING_W-1]}}, sp1} :
    (reg_req.addr == OFF_SP2) ? {{(DATA_W-READING_W){sp2[READING_W-1]}}, sp2} :
    (reg_req.addr == OFF_SP3) ? {{(DATA_W-READING_W){settings_reg.sp[2][READING_W-1]}}, settings_reg.sp[2]} :
    (reg_req.addr == OFF_SP4) ? {{(DATA_W-READING_W){settings_reg.sp[3][READING_W-1]}}, settings_reg.sp[3]} :
    (reg_req.addr == OFF_MAKE) ? {{(DATA_W-DELAY_W){1'b0}}, settings_reg.make_delay} :
    (reg_req.addr == OFF_BREAK) ? {{(DATA_W-DELAY_W){1'b0}}, settings_reg.break_delay} :
    (reg_req.addr == OFF_CONFIG) ? cfg_word :
    (reg_req.addr == OFF_PROG_DATA) ? {20'h0_0000, step_reg} :
    (reg_req.addr == OFF_STATUS) ? stat_word :
    (reg_req.addr == OFF_HYSTERESIS_ENABLE_BAND) ? {{(DATA_W-READING_W){1'b0}}, hysteresis_enable_band_reg} :
    (reg_req.addr == OFF_IRQ_STATUS) ? {{(DATA_W-NUM_SP){1'b0}}, irq_status_reg} :
    (reg_req.addr == OFF_IRQ_MASK) ? {{(DATA_W-NUM_SP){1'b0}}, irq_mask_reg} :
    (reg_req.addr == OFF_LAST_READING) ? {{(DATA_W-READING_W){last_reading_reg[READING_W-1]}}, last_reading_reg} :
    32'h0000_0000;

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= reg_req.rd ? read_word : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_reg;
  // Unfitted positions stay quiet but keep their indicator
  assign relay_drive = relay_state & RELAYS_FITTED;
  assign indicator = relay_state;
  assign irq = |(irq_status_reg & irq_mask_reg);

  a_relay_off_reset: assert property (@(posedge mclk) disable iff (rst)
    !evaluated_reg |-> relay_drive == 4'h0 && indicator == 4'h0)
    else $error("relay active before first reading");

  a_alarm_per_reading: assert property (@(posedge mclk) disable iff (rst)
    !reading.valid |=> alarm_reg == $past(alarm_reg))
    else $error("alarm moved without a reading");

  a_sp34_no_wait: assert property (@(posedge mclk) disable iff (rst)
    reading.valid |=> indicator[3:2] == $past(alarm_next[3:2]))
    else $error("setpoint three or four did not follow at once");

  a_top_never_trip: assert property (@(posedge mclk) disable iff (rst)
    reading.valid && settings_reg.sp[3] == READING_MAX && settings_reg.relay_direction_set[3] == DIR_HIGH
    |=> !alarm_reg[3])
    else $error("setpoint at range top tripped");

  a_bottom_never_trip: assert property (@(posedge mclk) disable iff (rst)
    reading.valid && settings_reg.sp[3] == READING_MIN && settings_reg.relay_direction_set[3] != DIR_HIGH
    |=> !alarm_reg[3])
    else $error("setpoint at range bottom tripped");

  a_dir_high_trip: assert property (@(posedge mclk) disable iff (rst)
    reading.valid && settings_reg.relay_direction_set[1] == DIR_HIGH && settings_reg.sp[1] != READING_MAX
    && $signed(reading.value) > $signed(settings_reg.sp[1]) |=> alarm_reg[1])
    else $error("high direction did not trip above setpoint");

  a_dir_low_clear: assert property (@(posedge mclk) disable iff (rst)
    reading.valid && settings_reg.relay_direction_set[1] != DIR_HIGH && !settings_reg.hysteresis_enable[1]
    && $signed(reading.value) >= $signed(settings_reg.sp[1]) |=> !alarm_reg[1])
    else $error("low direction alarm held without hysteresis");

  a_pump_low_fill: assert property (@(posedge mclk) disable iff (rst)
    reading.valid && band_active && settings_reg.relay_direction_set[0] != DIR_HIGH
    && $signed(reading.value) < $signed(sp1) && sp1 != READING_MIN |=> alarm_reg[0])
    else $error("pump fill did not start below setpoint one");

  a_pump_high_empty: assert property (@(posedge mclk) disable iff (rst)
    reading.valid && band_active && settings_reg.relay_direction_set[0] == DIR_HIGH
    && $signed(reading.value) <= $signed(sp1) |=> !alarm_reg[0])
    else $error("pump empty did not stop at setpoint one");

  a_pump_band_hold: assert property (@(posedge mclk) disable iff (rst)
    reading.valid && band_active && $signed(reading.value) > $signed(sp1)
    && $signed(reading.value) < $signed(sp2) |=> alarm_reg[0] == $past(alarm_reg[0]))
    else $error("pump band state changed inside the band");

  a_step_order: assert property (@(posedge mclk) disable iff (rst)
    prog_write && !prog_restart && step_reg == ST_PUMP |=> step_reg == ST_SP2)
    else $error("programming step skipped after pump");

  a_step_wrap: assert property (@(posedge mclk) disable iff (rst)
    prog_write && step_reg == ST_DIR ##1 !prog_write [*2] |-> step_reg == ST_SP1)
    else $error("programming did not wrap to setpoint one");

endmodule
